/* verilog/dma_channel_control.sv */
// two-channel dma control and status registers with request and acknowledge pin logic
//
// Operation
// - each control register is a 32-bit word; only the low half holds fields
// - reset and standby clear the registers; module standby keeps them unchanged
// - bits 31 to 16 read zero; software writes zero there
// - transfer end flag is clear-only: writing zero after reading one clears, writing one never sets
// - destination mode bits 15:14 give fixed, increment or decrement; 11 prohibited
// - destination step equals unit size: 1, 2, 4 or 16, negated for decrement
// - single address, memory to device: destination mode is ignored
// - source mode bits 13:12 give fixed, increment or decrement by unit size
// - sixteen-byte unit always advances the source address by 16
// - single address, device to memory: source mode is ignored
// - size bits 11:10 pick byte, word, longword or sixteen-byte unit
// - bit 9 picks external or peripheral requests (0) or self requests (1)
// - bit 8 picks ack in read or write cycle, or single mode direction
// - bit 7 makes the acknowledge output active low (0) or high (1)
// - bit 6 senses the request input by level (0) or edge (1)
// - bit 5 picks low or falling (0), high or rising (1) request sense
// - bit 4 picks cycle-steal (0) or burst (1) bus mode
// - bit 3 picks dual address (0) or single address (1) mode
// - with bit 2 set, a set transfer end flag raises the end interrupt
// - transfer end flag sets only when remaining count reaches zero
// - bit 0 enables transfers; clearing it stops an ongoing transfer
`timescale 1ns/10ps
module dma_channel_control
(
	// clock and reset
	input  wire logic                                          pclk,
	input  wire logic                                          presetn,
	// apb slave
	input  wire logic                                          psel,
	input  wire logic                                          penable,
	input  wire logic                                          pwrite,
	input  wire logic [dma_channel_control_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [31:0]                                   pwdata,
	output logic      [31:0]                                   prdata,
	output logic                                               pready,
	output logic                                               pslverr,
	// power states
	input  wire logic                                          standby,
	input  wire logic                                          module_standby,
	input  wire logic                                          master_enable,
	// external device pins
	input  wire logic [dma_channel_control_pkg::NUM_CH-1:0]    transfer_req_in,
	output logic      [dma_channel_control_pkg::NUM_CH-1:0]    transfer_ack_out,
	// transfer engine side
	input  dma_channel_control_pkg::evt_s                      evt [dma_channel_control_pkg::NUM_CH],
	output dma_channel_control_pkg::cfg_s                      cfg [dma_channel_control_pkg::NUM_CH],
	output logic      [dma_channel_control_pkg::NUM_CH-1:0]    transfer_end_irq
);

	// ---------------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------------
	logic [dma_channel_control_pkg::NUM_CH-1:0] hit;
	logic                                       mapped;
	logic                                       access;
	logic                                       setup;
	logic                                       wr_done;
	logic                                       rd_done;
	logic [dma_channel_control_pkg::CTL_W-1:0]  ctl_bits [dma_channel_control_pkg::NUM_CH];
	logic [31:0]                                rd_word;

	always_comb
	begin
		hit = '0;
		if (paddr == dma_channel_control_pkg::CTL0_OFF)
		begin
			hit[0] = 1'b1;
		end
		else if (paddr == dma_channel_control_pkg::CTL1_OFF)
		begin
			hit[1] = 1'b1;
		end
	end

	assign mapped  = |hit;
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	// zero wait states: every access completes in its first access cycle
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;
	// module standby freezes the register contents, so its writes are dropped
	assign wr_done = access & pwrite & mapped & ~module_standby;
	assign rd_done = access & ~pwrite & mapped;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (hit[0])
		begin
			rd_word = {dma_channel_control_pkg::UPPER_ZERO, ctl_bits[0]};
		end
		else if (hit[1])
		begin
			rd_word = {dma_channel_control_pkg::UPPER_ZERO, ctl_bits[1]};
		end
	end

	// read data is captured in the setup cycle so that it comes from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (setup && !pwrite)
		begin
			prdata <= rd_word;
		end
	end

	// ---------------------------------------------------------------------
	// per-channel logic
	// ---------------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < dma_channel_control_pkg::NUM_CH; ch++)
		begin : g_ch
			dma_channel_control_pkg::ctl_s ctl_q;
			dma_channel_control_pkg::ctl_s wr_val;
			logic                          wr_this;
			logic                          te_seen_q;
			logic                          te_set;
			logic                          te_clear;
			logic                          req_sync1_q;
			logic                          req_sync2_q;
			logic                          req_prev_q;
			logic                          edge_seen;
			logic                          level_seen;
			logic                          pend_q;
			logic                          run;
			logic                          ack_active;
			logic                          ack_q;
			logic                          src_ignored;
			logic                          dst_ignored;
			logic [7:0]                    unit_bytes;
			logic [7:0]                    src_step_d;
			logic [7:0]                    dst_step_d;
			logic [7:0]                    src_step_q;
			logic [7:0]                    dst_step_q;

			assign ctl_bits[ch] = ctl_q;
			assign wr_this      = wr_done & hit[ch];
			assign wr_val       = pwdata[dma_channel_control_pkg::CTL_W-1:0];

			// -------------------------------------------------------------
			// transfer end flag
			// -------------------------------------------------------------
			// the engine pulses count_zero_end only on a normal end; aborts leave it low
			assign te_set   = evt[ch].count_zero_end & ~module_standby;
			// a zero write clears only after the flag was read as one
			assign te_clear = wr_this & ~wr_val.transfer_end_flag & te_seen_q;

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					te_seen_q <= 1'b0;
				end
				else if (standby || wr_this)
				begin
					te_seen_q <= 1'b0;
				end
				else if (rd_done && hit[ch])
				begin
					te_seen_q <= ctl_q.transfer_end_flag;
				end
			end

			// -------------------------------------------------------------
			// control register
			// -------------------------------------------------------------
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					ctl_q <= dma_channel_control_pkg::CTL_RESET;
				end
				else if (standby)
				begin
					ctl_q <= dma_channel_control_pkg::CTL_RESET;
				end
				else if (!module_standby)
				begin
					if (wr_this)
					begin
						ctl_q                  <= wr_val;
						// writing one keeps the old value; set beats a same-cycle clear
						ctl_q.transfer_end_flag <= te_set | (ctl_q.transfer_end_flag & ~te_clear);
					end
					else if (te_set)
					begin
						ctl_q.transfer_end_flag <= 1'b1;
					end
				end
			end

			// a set end flag blocks a new start even with the enable bit high
			assign run = ctl_q.channel_enable & master_enable & ~ctl_q.transfer_end_flag;

			// -------------------------------------------------------------
			// request input synchroniser and detector
			// -------------------------------------------------------------
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					req_sync1_q <= 1'b0;
					req_sync2_q <= 1'b0;
					req_prev_q  <= 1'b0;
				end
				else
				begin
					req_sync1_q <= transfer_req_in[ch];
					req_sync2_q <= req_sync1_q;
					req_prev_q  <= req_sync2_q;
				end
			end

			assign level_seen = (req_sync2_q == ctl_q.request_sense_level);
			assign edge_seen  = (req_sync2_q == ctl_q.request_sense_level) &
			                    (req_prev_q != ctl_q.request_sense_level);

			// an edge is remembered until the engine takes it; a new edge wins
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pend_q <= 1'b0;
				end
				else if (!run || !ctl_q.request_detect_kind)
				begin
					pend_q <= 1'b0;
				end
				else if (edge_seen)
				begin
					pend_q <= 1'b1;
				end
				else if (evt[ch].req_taken)
				begin
					pend_q <= 1'b0;
				end
			end

			// -------------------------------------------------------------
			// acknowledge output
			// -------------------------------------------------------------
			always_comb
			begin
				ack_active = 1'b0;
				if (ctl_q.address_mode_select)
				begin
					// single address: the device is addressed for the whole unit
					ack_active = evt[ch].ack_read_phase | evt[ch].ack_write_phase;
				end
				else if (ctl_q.ack_phase_direction)
				begin
					ack_active = evt[ch].ack_write_phase;
				end
				else
				begin
					ack_active = evt[ch].ack_read_phase;
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					ack_q <= dma_channel_control_pkg::ACK_IDLE_RESET;
				end
				else
				begin
					ack_q <= (ack_active & run) ~^ ctl_q.ack_polarity;
				end
			end

			assign transfer_ack_out[ch] = ack_q;

			// -------------------------------------------------------------
			// address stepping
			// -------------------------------------------------------------
			always_comb
			begin
				unit_bytes = dma_channel_control_pkg::BYTES_BYTE;
				case (ctl_q.unit_size)
					dma_channel_control_pkg::UNIT_BYTE:
						unit_bytes = dma_channel_control_pkg::BYTES_BYTE;
					dma_channel_control_pkg::UNIT_WORD:
						unit_bytes = dma_channel_control_pkg::BYTES_WORD;
					dma_channel_control_pkg::UNIT_LONG:
						unit_bytes = dma_channel_control_pkg::BYTES_LONG;
					default:
						unit_bytes = dma_channel_control_pkg::BYTES_SIXTEEN;
				endcase
			end

			assign dst_ignored = ctl_q.address_mode_select & ~ctl_q.ack_phase_direction;
			assign src_ignored = ctl_q.address_mode_select & ctl_q.ack_phase_direction;

			always_comb
			begin
				dst_step_d = 8'h00;
				if (!dst_ignored)
				begin
					case (ctl_q.dest_step_mode)
						dma_channel_control_pkg::STEP_INC:
							dst_step_d = unit_bytes;
						dma_channel_control_pkg::STEP_DEC:
							dst_step_d = 8'(-unit_bytes);
						// fixed, and the prohibited code is treated as fixed
						default:
							dst_step_d = 8'h00;
					endcase
				end
			end

			always_comb
			begin
				src_step_d = 8'h00;
				if (ctl_q.unit_size == dma_channel_control_pkg::UNIT_SIXTEEN)
				begin
					src_step_d = dma_channel_control_pkg::BYTES_SIXTEEN;
				end
				else if (!src_ignored)
				begin
					case (ctl_q.src_step_mode)
						dma_channel_control_pkg::STEP_INC:
							src_step_d = unit_bytes;
						dma_channel_control_pkg::STEP_DEC:
							src_step_d = 8'(-unit_bytes);
						default:
							src_step_d = 8'h00;
					endcase
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					src_step_q <= 8'h00;
					dst_step_q <= 8'h00;
				end
				else
				begin
					src_step_q <= src_step_d;
					dst_step_q <= dst_step_d;
				end
			end

			// -------------------------------------------------------------
			// engine configuration and interrupt
			// -------------------------------------------------------------
			always_comb
			begin
				cfg[ch].run_enable    = run;
				cfg[ch].req_valid     = run & (ctl_q.self_request_select |
				                        (ctl_q.request_detect_kind ? pend_q : level_seen));
				cfg[ch].burst_mode    = ctl_q.bus_mode_select;
				cfg[ch].single_mode   = ctl_q.address_mode_select;
				cfg[ch].dir_to_memory = ctl_q.ack_phase_direction;
				cfg[ch].unit_size     = ctl_q.unit_size;
				cfg[ch].src_step      = src_step_q;
				cfg[ch].dst_step      = dst_step_q;
			end

			assign transfer_end_irq[ch] = ctl_q.end_irq_enable & ctl_q.transfer_end_flag;
		end
	endgenerate

endmodule : dma_channel_control

/* verilog/dma_channel_control_pkg.sv */
// constants, register layout and carrier types for the dma channel control block
package dma_channel_control_pkg;

	// ---------------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------------
	localparam int          NUM_CH     = 2;
	localparam int          ADDR_W     = 8;
	localparam int          CTL_W      = 16;
	localparam int          STEP_W     = 8;

	// ---------------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------------
	localparam logic [7:0]  CTL0_OFF   = 8'h00;
	localparam logic [7:0]  CTL1_OFF   = 8'h10;

	// ---------------------------------------------------------------------
	// reset values and field positions
	// ---------------------------------------------------------------------
	localparam logic [15:0] CTL_RESET  = 16'h0000;
	localparam logic [15:0] UPPER_ZERO = 16'h0000;
	localparam int          TE_BIT     = 1;
	localparam logic        ACK_IDLE_RESET = 1'b1;

	// ---------------------------------------------------------------------
	// field encodings
	// ---------------------------------------------------------------------
	typedef enum logic [1:0] {
		STEP_FIXED = 2'b00,
		STEP_INC   = 2'b01,
		STEP_DEC   = 2'b10,
		STEP_RSVD  = 2'b11
	} step_mode_e;

	typedef enum logic [1:0] {
		UNIT_BYTE  = 2'b00,
		UNIT_WORD  = 2'b01,
		UNIT_LONG  = 2'b10,
		UNIT_SIXTEEN = 2'b11
	} unit_size_e;

	localparam logic [7:0]  BYTES_BYTE = 8'h01;
	localparam logic [7:0]  BYTES_WORD = 8'h02;
	localparam logic [7:0]  BYTES_LONG = 8'h04;
	localparam logic [7:0]  BYTES_SIXTEEN = 8'h10;

	// ---------------------------------------------------------------------
	// channel control register, bit 15 first
	// ---------------------------------------------------------------------
	typedef struct packed {
		step_mode_e dest_step_mode;
		step_mode_e src_step_mode;
		unit_size_e unit_size;
		logic       self_request_select;
		logic       ack_phase_direction;
		logic       ack_polarity;
		logic       request_detect_kind;
		logic       request_sense_level;
		logic       bus_mode_select;
		logic       address_mode_select;
		logic       end_irq_enable;
		logic       transfer_end_flag;
		logic       channel_enable;
	} ctl_s;

	// events from the transfer engine, per channel
	typedef struct packed {
		logic       count_zero_end;
		logic       req_taken;
		logic       ack_read_phase;
		logic       ack_write_phase;
	} evt_s;

	// configuration handed to the transfer engine, per channel
	typedef struct packed {
		logic              run_enable;
		logic              req_valid;
		logic              burst_mode;
		logic              single_mode;
		logic              dir_to_memory;
		unit_size_e        unit_size;
		logic [STEP_W-1:0] src_step;
		logic [STEP_W-1:0] dst_step;
	} cfg_s;

endpackage : dma_channel_control_pkg

/* testbench/dma_channel_control_sva.sv */
// assertion checker for the dma channel control ports
`timescale 1ns/10ps
module dma_channel_control_sva
(
	// clock and reset
	input wire logic                          pclk,
	input wire logic                          presetn,
	// apb
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pwrite,
	input wire logic [7:0]                    paddr,
	input wire logic [31:0]                   prdata,
	input wire logic                          pready,
	input wire logic                          pslverr,
	// power and engine
	input wire logic                          standby,
	input wire logic                          module_standby,
	input wire logic                          master_enable,
	input dma_channel_control_pkg::evt_s      evt [2],
	input dma_channel_control_pkg::cfg_s      cfg [2],
	input wire logic [1:0]                    transfer_end_irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic bad;
	assign acc = psel && penable;
	assign bad = paddr != dma_channel_control_pkg::CTL0_OFF
		&& paddr != dma_channel_control_pkg::CTL1_OFF;

	// ---------------------------------------------------------------------
	// bus
	// ---------------------------------------------------------------------
	chk_zero_wait: assert property (acc |-> pready)
		else $error("access without ready");
	chk_unmapped_err: assert property (acc && bad |-> pslverr && (pwrite || prdata == 0))
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (acc && !bad |-> !pslverr)
		else $error("mapped access refused");
	chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper half not zero");

	// ---------------------------------------------------------------------
	// channel state
	// ---------------------------------------------------------------------
	chk_flag_halts: assert property (evt[0].count_zero_end && !standby && !module_standby
		|=> !cfg[0].run_enable)
		else $error("end event left channel running");
	chk_irq_halted: assert property (transfer_end_irq[0] |-> !cfg[0].run_enable)
		else $error("irq while running");
	chk_run_master: assert property (cfg[0].run_enable || cfg[1].run_enable |-> master_enable)
		else $error("run without master enable");
	chk_req_run: assert property (cfg[1].req_valid |-> cfg[1].run_enable)
		else $error("request while stopped");
	chk_sixteen_src: assert property ((cfg[0].unit_size == dma_channel_control_pkg::UNIT_SIXTEEN)[*2]
		|-> cfg[0].src_step == 8'h10)
		else $error("sixteen byte source step wrong");
	chk_standby_clr: assert property (standby |=> !cfg[0].run_enable && transfer_end_irq == 2'b00
		&& cfg[0].unit_size == dma_channel_control_pkg::UNIT_BYTE)
		else $error("standby did not clear");

	cov_end: cover property (evt[0].count_zero_end);
	cov_unmapped: cover property (acc && bad);
	cov_standby: cover property (standby);
endmodule : dma_channel_control_sva

bind dma_channel_control dma_channel_control_sva u_sva
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.standby(standby), .module_standby(module_standby), .master_enable(master_enable),
	.evt(evt), .cfg(cfg), .transfer_end_irq(transfer_end_irq)
);

/* testbench/ext_device.sv */
// external device model raising a request pin and waiting for its acknowledge
`timescale 1ns/10ps
module ext_device
(
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// command and pins
	input  wire logic go,
	input  wire logic ack,
	output logic      req
);
	logic pend_q;
	// high level and rising edge sense, active-high acknowledge
	assign req = pend_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_q <= 1'b0;
		else if (go)
			pend_q <= 1'b1;
		else if (ack)
			pend_q <= 1'b0;
	end
endmodule : ext_device

/* testbench/dma_channel_control_tb.sv */
// self-checking bench for the dma channel control block
`timescale 1ns/10ps
module dma_channel_control_tb;
	localparam logic [7:0] A0 = dma_channel_control_pkg::CTL0_OFF;
	localparam logic [7:0] A1 = dma_channel_control_pkg::CTL1_OFF;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic        pready, pslverr, err, go = 1'b0;
	logic        standby = 1'b0, module_standby = 1'b0, master_enable = 1'b0;
	wire  [1:0]  req_in;
	logic [1:0]  ack_out, irq;
	dma_channel_control_pkg::evt_s evt [2] = '{default: '0};
	dma_channel_control_pkg::cfg_s cfg [2];
	int          failures = 0, compares = 0;

	always #50 pclk = ~pclk;
	assign req_in[0] = 1'b0;
	dma_channel_control dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.standby(standby), .module_standby(module_standby), .master_enable(master_enable),
		.transfer_req_in(req_in), .transfer_ack_out(ack_out), .evt(evt), .cfg(cfg),
		.transfer_end_irq(irq)
	);
	ext_device peer (.pclk(pclk), .presetn(presetn), .go(go), .ack(ack_out[1]), .req(req_in[1]));

	// ---------------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// steps lag the register by one cycle, so settle to the second falling edge past it
	task automatic put(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (2) @(negedge pclk);
	endtask : put

	task automatic pulse_go();
		@(posedge pclk);
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (5) @(negedge pclk);
	endtask : pulse_go

	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	// ---------------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------------
	task automatic t_map();
		apb(1'b0, A0, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b1, A1, 32'hABCD_ABFE);
		apb(1'b0, A1, 32'h0000_0000);
		check(rd, 32'h0000_ABFC);
		apb(1'b1, 8'h20, 32'h0000_1234);
		check(err, 1'b1);
		apb(1'b0, 8'h20, 32'h0000_0000);
		check({31'h0000_0000, err}, 32'h0000_0001);
		check(rd, 32'h0000_0000);
		apb(1'b0, A0, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b1, A1, 32'h0000_0000);
	endtask : t_map

	task automatic t_steps();
		logic [1:0]  dm, sm, ts;
		logic [7:0]  u, de, se;
		logic [31:0] got;
		for (int i = 0; i < 36; i++)
		begin
			ts = 2'(i / 9);
			dm = 2'(i / 3 % 3);
			sm = 2'(i % 3);
			u = (ts == 2'b11) ? 8'h10 : 8'h01 << ts;
			de = dm == 2'b01 ? u : dm == 2'b10 ? -u : 8'h00;
			se = ts == 2'b11 ? 8'h10 : sm == 2'b01 ? u : sm == 2'b10 ? -u : 8'h00;
			// auto requests keep the sixteen-byte unit legal; no destination here is internal memory
			put(A0, {16'h0000, dm, sm, ts, 10'h200});
			got = {cfg[0].unit_size, cfg[0].dst_step, cfg[0].src_step};
			check(got, {ts, de, se});
		end
		put(A0, 32'h0000_5808);
		got = {cfg[0].single_mode, cfg[0].dir_to_memory, cfg[0].dst_step, cfg[0].src_step};
		check(got, 32'h0002_0004);
		put(A0, 32'h0000_5908);
		got = {cfg[0].single_mode, cfg[0].dir_to_memory, cfg[0].dst_step, cfg[0].src_step};
		check(got, 32'h0003_0400);
		// burst only together with edge detection
		put(A0, 32'h0000_0050);
		check(cfg[0].burst_mode, 1'b1);
	endtask : t_steps

	task automatic t_flag();
		@(posedge pclk);
		master_enable <= 1'b1;
		put(A0, 32'h0000_0205);
		check({cfg[0].run_enable, cfg[0].req_valid, irq[0]}, 3'b110);
		@(posedge pclk);
		evt[0].count_zero_end <= 1'b1;
		@(posedge pclk);
		evt[0].count_zero_end <= 1'b0;
		@(negedge pclk);
		check({cfg[0].run_enable, irq[0]}, 2'b01);
		apb(1'b1, A0, 32'h0000_0205);
		apb(1'b0, A0, 32'h0000_0000);
		check(rd, 32'h0000_0207);
		put(A0, 32'h0000_0205);
		check({cfg[0].run_enable, irq[0]}, 2'b10);
		put(A0, 32'h0000_0204);
		check(cfg[0].run_enable, 1'b0);
	endtask : t_flag

	task automatic t_req();
		put(A1, 32'h0000_00A1);
		pulse_go();
		check(cfg[1].req_valid, 1'b1);
		@(posedge pclk);
		evt[1].ack_read_phase <= 1'b1;
		repeat (2) @(negedge pclk);
		check(ack_out[1], 1'b1);
		@(posedge pclk);
		evt[1].ack_read_phase <= 1'b0;
		evt[1].ack_write_phase <= 1'b1;
		repeat (5) @(negedge pclk);
		check({ack_out[1], cfg[1].req_valid}, 2'b00);
		put(A1, 32'h0000_01A1);
		check(ack_out[1], 1'b1);
		put(A1, 32'h0000_0021);
		check(ack_out[1], 1'b1);
		put(A1, 32'h0000_00E1);
		pulse_go();
		check(cfg[1].req_valid, 1'b1);
		@(posedge pclk);
		evt[1].req_taken <= 1'b1;
		@(posedge pclk);
		evt[1].req_taken <= 1'b0;
		repeat (2) @(negedge pclk);
		check({req_in[1], cfg[1].req_valid}, 2'b10);
	endtask : t_req

	task automatic t_power();
		apb(1'b1, A0, 32'h0000_1244);
		@(posedge pclk);
		module_standby <= 1'b1;
		apb(1'b1, A0, 32'h0000_0000);
		apb(1'b0, A0, 32'h0000_0000);
		check(rd, 32'h0000_1244);
		@(posedge pclk);
		module_standby <= 1'b0;
		standby <= 1'b1;
		@(posedge pclk);
		standby <= 1'b0;
		apb(1'b0, A0, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b1, A1, 32'h0000_0044);
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		check(ack_out, 2'b11);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A1, 32'h0000_0000);
		check(rd, 32'h0000_0000);
	endtask : t_power

	initial
	begin
		#500_000;
		failures++;
		conclude();
	end

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_map();
		t_steps();
		t_flag();
		t_req();
		t_power();
		conclude();
	end
endmodule : dma_channel_control_tb
